// file: include/nrd_pkg.sv
// Shared constants for the non-maskable interrupt control unit
package nrd_pkg;

   // Register byte offsets on the bus
   localparam logic [7:0] ADDR_CONTROL = 8'h00;
   localparam logic [7:0] ADDR_UNLOCK = 8'h04;
   localparam logic [7:0] ADDR_IRQ_STATUS = 8'h08;
   localparam logic [7:0] ADDR_IRQ_MASK = 8'h0c;
   localparam logic [7:0] ADDR_COUNTER = 8'h10;

   // Field positions inside the control register
   localparam int BIT_WDT_RUN = 24;
   localparam int BIT_SOFT_NMI = 23;
   localparam int BIT_GEN_NMI = 19;
   localparam int BIT_CLK_FAIL = 17;
   localparam int BIT_WDT_SLEEP = 16;
   localparam int RELOAD_W = 16;

   // Reset values and counter compare constants
   localparam logic [31:0] CONTROL_RESET = 32'h0000_0000;
   localparam logic [15:0] RELOAD_RESET = 16'h0000;
   localparam logic [15:0] RELOAD_NO_DELAY = 16'h0000;
   localparam logic [15:0] COUNT_LAST = 16'h0001;

   // Unlock keys, values are arbitrary
   localparam logic [31:0] UNLOCK_KEY1 = 32'h0000_a5a5;
   localparam logic [31:0] UNLOCK_KEY2 = 32'h0000_5a5a;

   // Interrupt status and mask layout
   localparam int IRQ_W = 3;
   localparam int IRQ_NMI = 0;
   localparam int IRQ_RESET = 1;
   localparam int IRQ_CANCEL = 2;
   localparam logic [IRQ_W-1:0] IRQ_RESET_VAL = 3'h0;

   // Synchroniser depth plus one delay stage for edge detection
   localparam int SYNC_W = 3;

endpackage

// file: include/nrd_cnt_if.sv
`timescale 1ns/1ns
// Link between the control logic and the reset delay counter
interface nrd_cnt_if;
   logic start;
   logic cancel;
   logic [15:0] reload;
   logic fire;
   logic busy;
   logic [15:0] count;

   modport ctrl (output start, output cancel, output reload,
                 input fire, input busy, input count);
   modport cnt (input start, input cancel, input reload,
                output fire, output busy, output count);
endinterface

// file: core/nrd_delay_counter.sv
`timescale 1ns/1ns
// Reset delay down-counter
module nrd_delay_counter (
   input wire logic sys_clk,
   input wire logic sys_rst,
   nrd_cnt_if.cnt cnt
);

   typedef struct packed {
      logic busy;
      logic fire;
      logic [15:0] count;
   } nrd_cnt_state_t;

   nrd_cnt_state_t cnt_reg;
   nrd_cnt_state_t cnt_next;

   // Cancel outranks start so a cleared event never leaves a reset pending
   always_comb begin
      cnt_next = cnt_reg;
      cnt_next.fire = 1'b0;
      // RULE10 - cancel on clear
      if (cnt.cancel) begin
         cnt_next.busy = 1'b0;
         cnt_next.count = '0;
      end else if (cnt.start) begin
         // RULE9 - zero means immediate
         if (cnt.reload == nrd_pkg::RELOAD_NO_DELAY) begin
            cnt_next.fire = 1'b1;
            cnt_next.busy = 1'b0;
         end else begin
            // RULE8 - load reload value
            cnt_next.busy = 1'b1;
            cnt_next.count = cnt.reload;
         end
      end else if (cnt_reg.busy) begin
         if (cnt_reg.count == nrd_pkg::COUNT_LAST) begin
            cnt_next.fire = 1'b1;
            cnt_next.busy = 1'b0;
            cnt_next.count = '0;
         end else begin
            cnt_next.count = cnt_reg.count - 16'h0001;
         end
      end
   end

   // State register
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         cnt_reg <= '0;
      end else begin
         cnt_reg <= cnt_next;
      end
   end

   // Outputs straight from flops
   assign cnt.fire = cnt_reg.fire;
   assign cnt.busy = cnt_reg.busy;
   assign cnt.count = cnt_reg.count;

endmodule // nrd_delay_counter

// file: core/nrd_top.sv
// Chosen here: the Wishbone register port and the register offsets.
`timescale 1ns/1ns
// How it works
// RULE1 - Run-mode watchdog expiry sets the run flag and raises the NMI.
// RULE2 - Software writing one to the run flag makes a watchdog NMI and starts counting.
// RULE3 - Soft trigger bit raises the NMI and reads one while recorded.
// RULE4 - General trigger bit raises a general NMI and reads one while recorded.
// RULE5 - Clock failure detection sets the clock fail flag and raises the NMI.
// RULE6 - Software setting clock fail raises the NMI without requesting a clock switch.
// RULE7 - Watchdog expiry in sleep sets the sleep flag and wakes; it raises the NMI.
// RULE8 - The 16-bit reload gives system clock cycles before the device reset.
// RULE9 - Reload of zero asserts device reset right after the NMI.
// RULE10 - Clearing the run flag before the count ends prevents the reset.
// RULE11 - Only the run-mode watchdog event starts the reset counter.
// RULE12 - Control writes are ignored unless the unlock sequence was done first.
// RULE13 - Unimplemented control bits, including the top seven, read as zero.
// RULE14 - All flags and counter reset to zero; NMI stays high while any flag is set.
module nrd_top (
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic wdt_expire,
   input wire logic sleep_active,
   input wire logic clock_failure_monitor,
   output logic nmi_req,
   output logic device_reset_req,
   output logic wake_req,
   output logic clock_switch_req,
   output logic irq
);

   typedef struct packed {
      // Pin synchronisers, stage 0 is read only by stage 1
      logic [nrd_pkg::SYNC_W-1:0] wdt_s;
      logic [1:0] slp_s;
      logic [nrd_pkg::SYNC_W-1:0] cf_s;
      // Source flags
      logic wdt_run_timeout_flag;
      logic soft_nmi_trigger;
      logic general_nmi_trigger;
      logic clock_fail_flag;
      logic wdt_sleep_timeout_flag;
      logic [15:0] reset_delay_reload;
      // Write protection
      logic key_stage;
      logic unlocked;
      // Block interrupt
      logic [nrd_pkg::IRQ_W-1:0] irq_stat;
      logic [nrd_pkg::IRQ_W-1:0] irq_mask;
      // Counter start request
      logic cnt_start;
      // Bus answer
      logic ack;
      logic [31:0] rdata;
      // Registered outputs
      logic nmi;
      logic dev_rst;
      logic wake;
      logic clk_sw;
      logic irq;
   } nrd_state_t;

   nrd_state_t st_reg;
   nrd_state_t st_next;

   nrd_cnt_if cnt_bus ();

   // Reset delay counter
   nrd_delay_counter u_delay (
      .sys_clk (sys_clk),
      .sys_rst (sys_rst),
      .cnt (cnt_bus.cnt)
   );

   // Control register image as software sees it
   function automatic logic [31:0] ctl_image(input nrd_state_t s);
      logic [31:0] v;
      v = nrd_pkg::CONTROL_RESET;
      // RULE13 - unused bits zero
      v[nrd_pkg::BIT_WDT_RUN] = s.wdt_run_timeout_flag;
      v[nrd_pkg::BIT_SOFT_NMI] = s.soft_nmi_trigger;
      v[nrd_pkg::BIT_GEN_NMI] = s.general_nmi_trigger;
      v[nrd_pkg::BIT_CLK_FAIL] = s.clock_fail_flag;
      v[nrd_pkg::BIT_WDT_SLEEP] = s.wdt_sleep_timeout_flag;
      v[nrd_pkg::RELOAD_W-1:0] = s.reset_delay_reload;
      return v;
   endfunction

   // Byte-lane merge so narrow writes keep the other lanes
   function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0] sel);
      logic [31:0] v;
      v = old_v;
      for (int i = 0; i < 4; i++) begin
         if (sel[i]) begin
            v[i*8 +: 8] = new_v[i*8 +: 8];
         end
      end
      return v;
   endfunction

   // Word decode ignores the two byte-select address bits
   function automatic logic hit(input logic [7:0] adr, input logic [7:0] base);
      return adr[7:2] == base[7:2];
   endfunction

   // Next-state logic
   always_comb begin
      logic req;
      logic taken;
      logic wr;
      logic rd;
      logic wctl;
      logic [31:0] wval;
      logic wdt_hit;
      logic asleep;
      logic cf_hit;
      logic any_flag;
      logic [nrd_pkg::IRQ_W-1:0] ev;
      logic [31:0] rval;

      req = 1'b0;
      taken = 1'b0;
      wr = 1'b0;
      rd = 1'b0;
      wctl = 1'b0;
      wval = '0;
      wdt_hit = 1'b0;
      asleep = 1'b0;
      cf_hit = 1'b0;
      any_flag = 1'b0;
      ev = '0;
      rval = '0;

      st_next = st_reg;

      // Two flops on each pin, a third only for the edge detector
      st_next.wdt_s = {st_reg.wdt_s[nrd_pkg::SYNC_W-2:0], wdt_expire};
      st_next.slp_s = {st_reg.slp_s[0], sleep_active};
      st_next.cf_s = {st_reg.cf_s[nrd_pkg::SYNC_W-2:0], clock_failure_monitor};

      wdt_hit = st_reg.wdt_s[1] & ~st_reg.wdt_s[2];
      asleep = st_reg.slp_s[1];
      cf_hit = st_reg.cf_s[1] & ~st_reg.cf_s[2];

      // Pulse outputs last one cycle
      st_next.wake = 1'b0;
      st_next.clk_sw = 1'b0;
      st_next.cnt_start = 1'b0;

      // Ack comes one cycle after the request; the action is at the ack edge
      req = wb_cyc_i & wb_stb_i;
      st_next.ack = req & ~st_reg.ack;
      taken = req & st_reg.ack;
      wr = taken & wb_we_i;
      rd = taken & ~wb_we_i;

      // Unlock key sequence; any other write to the key word relocks
      if (wr && hit(wb_adr_i, nrd_pkg::ADDR_UNLOCK)) begin
         if (wb_dat_i == nrd_pkg::UNLOCK_KEY1) begin
            st_next.key_stage = 1'b1;
            st_next.unlocked = 1'b0;
         end else if (st_reg.key_stage && wb_dat_i == nrd_pkg::UNLOCK_KEY2) begin
            st_next.key_stage = 1'b0;
            st_next.unlocked = 1'b1;
         end else begin
            st_next.key_stage = 1'b0;
            st_next.unlocked = 1'b0;
         end
      end

      // RULE12 - locked writes dropped
      wctl = wr && hit(wb_adr_i, nrd_pkg::ADDR_CONTROL) && st_reg.unlocked;
      wval = lane_merge(ctl_image(st_reg), wb_dat_i, wb_sel_i);

      // Software image first, so a hardware set in the same cycle wins
      if (wctl) begin
         // RULE2 - software run flag
         st_next.wdt_run_timeout_flag = wval[nrd_pkg::BIT_WDT_RUN];
         // RULE3 - soft trigger
         st_next.soft_nmi_trigger = wval[nrd_pkg::BIT_SOFT_NMI];
         // RULE4 - general trigger
         st_next.general_nmi_trigger = wval[nrd_pkg::BIT_GEN_NMI];
         // RULE6 - flag only, no switch
         st_next.clock_fail_flag = wval[nrd_pkg::BIT_CLK_FAIL];
         // RULE7 - software sleep flag
         st_next.wdt_sleep_timeout_flag = wval[nrd_pkg::BIT_WDT_SLEEP];
         // RULE8 - reload field
         st_next.reset_delay_reload = wval[nrd_pkg::RELOAD_W-1:0];
      end

      // RULE1 - run-mode expiry
      if (wdt_hit && !asleep) begin
         st_next.wdt_run_timeout_flag = 1'b1;
      end

      // RULE7 - sleep expiry wakes
      if (wdt_hit && asleep) begin
         st_next.wdt_sleep_timeout_flag = 1'b1;
         st_next.wake = 1'b1;
      end

      // RULE5 - monitor failure
      if (cf_hit) begin
         st_next.clock_fail_flag = 1'b1;
         st_next.clk_sw = 1'b1; // Only a real failure asks for the clock switch
      end

      // RULE14 - NMI while any flag
      any_flag = st_next.wdt_run_timeout_flag | st_next.soft_nmi_trigger |
                 st_next.general_nmi_trigger | st_next.clock_fail_flag |
                 st_next.wdt_sleep_timeout_flag;
      st_next.nmi = any_flag;

      // RULE11 - only run flag starts
      st_next.cnt_start = st_next.wdt_run_timeout_flag & ~st_reg.wdt_run_timeout_flag;

      // Device reset request follows the counter expiry by one flop
      st_next.dev_rst = cnt_bus.fire;

      // Block events for the interrupt status
      ev[nrd_pkg::IRQ_NMI] = any_flag & ~st_reg.nmi;
      ev[nrd_pkg::IRQ_RESET] = cnt_bus.fire;
      ev[nrd_pkg::IRQ_CANCEL] = cnt_bus.busy & ~st_reg.wdt_run_timeout_flag;

      // Read clears status, but an event in the same cycle survives
      if (rd && hit(wb_adr_i, nrd_pkg::ADDR_IRQ_STATUS)) begin
         st_next.irq_stat = ev;
      end else begin
         st_next.irq_stat = st_reg.irq_stat | ev;
      end

      // Mask register takes the low bits of the word
      if (wr && hit(wb_adr_i, nrd_pkg::ADDR_IRQ_MASK)) begin
         st_next.irq_mask = wb_dat_i[nrd_pkg::IRQ_W-1:0];
      end

      st_next.irq = |(st_next.irq_stat & st_next.irq_mask);

      // Read data is captured when the ack is issued; unmapped reads zero
      if (hit(wb_adr_i, nrd_pkg::ADDR_CONTROL)) begin
         rval = ctl_image(st_reg);
      end else if (hit(wb_adr_i, nrd_pkg::ADDR_UNLOCK)) begin
         rval = {30'h0, st_reg.key_stage, st_reg.unlocked};
      end else if (hit(wb_adr_i, nrd_pkg::ADDR_IRQ_STATUS)) begin
         rval = {29'h0, st_reg.irq_stat | ev};
      end else if (hit(wb_adr_i, nrd_pkg::ADDR_IRQ_MASK)) begin
         rval = {29'h0, st_reg.irq_mask};
      end else if (hit(wb_adr_i, nrd_pkg::ADDR_COUNTER)) begin
         rval = {15'h0, cnt_bus.busy, cnt_bus.count};
      end
      if (req && !st_reg.ack) begin
         st_next.rdata = rval;
      end
   end

   // Synchronous reset to constants only
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   // Counter link; cancel whenever the run flag is clear
   assign cnt_bus.start = st_reg.cnt_start;
   // RULE10 - clear cancels count
   assign cnt_bus.cancel = ~st_reg.wdt_run_timeout_flag;
   assign cnt_bus.reload = st_reg.reset_delay_reload;

   // Outputs straight from flops
   assign wb_dat_o = st_reg.rdata;
   assign wb_ack_o = st_reg.ack;
   assign nmi_req = st_reg.nmi;
   assign device_reset_req = st_reg.dev_rst;
   assign wake_req = st_reg.wake;
   assign clock_switch_req = st_reg.clk_sw;
   assign irq = st_reg.irq;

endmodule // nrd_top

// file: core/nrd_top_fix.sv
`timescale 1ns/1ns

// file: verification/nrd_core_model.sv
`timescale 1ns/1ns
// Core side: counts NMI entries, device resets and wake-ups
module nrd_core_model (
   input wire logic sys_clk,
   input wire logic nmi_req,
   input wire logic device_reset_req,
   input wire logic wake_req,
   output int n_nmi,
   output int n_rst,
   output int n_wake
);
   logic nmi_last;
   initial begin
      n_nmi = 0;
      n_rst = 0;
      n_wake = 0;
      nmi_last = 1'b0;
   end
   // A level request is taken once per rise, as a core would enter its handler
   always @(posedge sys_clk) begin
      if (nmi_req === 1'b1 && nmi_last !== 1'b1) n_nmi <= n_nmi + 1;
      if (device_reset_req === 1'b1) n_rst <= n_rst + 1;
      if (wake_req === 1'b1) n_wake <= n_wake + 1;
      nmi_last <= nmi_req;
   end
endmodule // nrd_core_model

// file: verification/nrd_top_props.sv
`timescale 1ns/1ns
// Port-level checks of the NMI control unit
module nrd_top_props (
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic wb_ack_o,
   input wire logic wdt_expire,
   input wire logic sleep_active,
   input wire logic clock_failure_monitor,
   input wire logic nmi_req,
   input wire logic device_reset_req,
   input wire logic wake_req,
   input wire logic clock_switch_req,
   input wire logic irq
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (sys_rst);
   // Bus request steps
   sequence req_s;
      wb_cyc_i && wb_stb_i && !wb_ack_o;
   endsequence
   sequence ack_s;
      wb_ack_o ##1 !wb_ack_o;
   endsequence
   ack_resp_a: assert property (req_s |=> ack_s) else $error("bad ack");
   ack_idle_a: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o) else $error("stray ack");
   rst_quiet_a: assert property ($fell(sys_rst) |-> !nmi_req && !irq) else $error("not quiet");
   // Flags only drop through a bus write
   nmi_hold_a: assert property (nmi_req && !(wb_cyc_i && wb_we_i) |=> nmi_req)
      else $error("nmi dropped");
   rst_pulse_a: assert property (device_reset_req |=> !device_reset_req) else $error("reset long");
   rst_nmi_a: assert property (device_reset_req |-> nmi_req) else $error("reset without nmi");
   no_switch_a: assert property (clock_switch_req |-> $past(clock_failure_monitor, 3))
      else $error("clock switch without failure");
   wdt_nmi_a: assert property ($rose(wdt_expire) |-> ##[1:8] nmi_req) else $error("no nmi");
   cf_nmi_a: assert property ($rose(clock_failure_monitor) |-> ##[1:8] nmi_req)
      else $error("no clock nmi");
   sleep_wake_a: assert property ($rose(wdt_expire) && sleep_active |-> ##[1:8] wake_req)
      else $error("no wake");
endmodule // nrd_top_props
bind nrd_top nrd_top_props u_nrd_top_props (.*);

// file: verification/nrd_top_tb.sv
`timescale 1ns/1ns
// Register-level tests of the NMI control unit
module nrd_top_tb;
   localparam logic [7:0] A_CTL = nrd_pkg::ADDR_CONTROL;
   localparam logic [7:0] A_UNL = nrd_pkg::ADDR_UNLOCK;
   localparam logic [7:0] A_STA = nrd_pkg::ADDR_IRQ_STATUS;
   localparam logic [7:0] A_MSK = nrd_pkg::ADDR_IRQ_MASK;
   localparam logic [7:0] A_CNT = nrd_pkg::ADDR_COUNTER;
   logic sys_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic cyc = 1'b0, stb = 1'b0, we = 1'b0, wdt = 1'b0, slp = 1'b0, cfm = 1'b0;
   logic [7:0] adr = 8'h00;
   logic [31:0] dat = 32'h0000_0000;
   logic [31:0] rdo, rdat;
   logic ack, nmi, drst, wake, csw, irq;
   int n_nmi, n_rst, n_wake, k;
   int mismatches = 0;
   int n_checks = 0;
   int n_sw = 0;
   logic [15:0] dly [3] = '{16'h0000, 16'h0005, 16'h0011};

   // 10 MHz system clock
   always #50 sys_clk = ~sys_clk;

   // Clock switch requests, one per real failure
   always @(posedge sys_clk) begin
      if (csw === 1'b1) n_sw <= n_sw + 1;
   end

   nrd_top u_nrd_top (.sys_clk(sys_clk), .sys_rst(sys_rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat), .wb_dat_o(rdo),
      .wb_ack_o(ack), .wdt_expire(wdt), .sleep_active(slp), .clock_failure_monitor(cfm),
      .nmi_req(nmi), .device_reset_req(drst), .wake_req(wake), .clock_switch_req(csw),
      .irq(irq));
   nrd_core_model u_nrd_core_model (.sys_clk(sys_clk), .nmi_req(nmi),
      .device_reset_req(drst), .wake_req(wake), .n_nmi(n_nmi), .n_rst(n_rst),
      .n_wake(n_wake));

   // Ends the run with the verdict
   task automatic test_done;
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // Classic cycle; held until ack is sampled, then one idle cycle; a hang ends at the watchdog
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      dat <= d;
      do begin
         @(posedge sys_clk);
      end while (ack !== 1'b1);
      rdat = rdo;
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge sys_clk);
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      chk(rdat, e);
   endtask

   task automatic idle(input int n);
      repeat (n) @(posedge sys_clk);
   endtask

   // Pulse one event pin for four cycles
   task automatic pin(input logic c);
      idle(4);
      if (c) cfm <= 1'b1;
      else wdt <= 1'b1;
      idle(4);
      cfm <= 1'b0;
      wdt <= 1'b0;
      idle(4);
   endtask

   // Watchdog: far beyond the few hundred cycles of the tests
   initial begin
      #2_000_000;
      mismatches++;
      test_done();
   end

   initial begin
      idle(6);
      sys_rst <= 1'b0;
      idle(4);
      rd(A_CTL, 32'h0);
      rd(A_CNT, 32'h0);
      rd(8'h20, 32'h0);
      wr(A_CTL, 32'h0080_0000);
      rd(A_CTL, 32'h0);
      $display("test reset and lock done");
      wr(A_UNL, nrd_pkg::UNLOCK_KEY1);
      wr(A_UNL, nrd_pkg::UNLOCK_KEY2);
      wr(A_MSK, 32'h0);
      wr(A_CTL, 32'hfeff_0000);
      rd(A_CTL, 32'h008b_0000);
      rd(A_CNT, 32'h0);
      chk(nmi, 1'b1);
      chk(irq, 1'b0);
      chk(csw, 1'b0);
      wr(A_MSK, 32'h7);
      idle(2);
      chk(irq, 1'b1);
      wr(A_CTL, 32'h0);
      idle(3);
      chk(nmi, 1'b0);
      rd(A_STA, 32'h1);
      idle(2);
      chk(irq, 1'b0);
      chk(n_rst, 0);
      $display("test soft triggers done");
      foreach (dly[i]) begin
         wr(A_CTL, {16'h0100, dly[i]});
         k = 1;
         while (drst !== 1'b1 && k < 300) begin
            @(posedge sys_clk);
            k++;
         end
         chk(k, 3 + dly[i]);
         wr(A_CTL, 32'h0);
      end
      rd(A_STA, 32'h3);
      wr(A_CTL, 32'h0100_0028);
      bus(1'b0, A_CNT, 32'h0);
      chk(rdat[16], 1'b1);
      wr(A_CTL, 32'h0000_0028);
      idle(60);
      chk(n_rst, 3);
      rd(A_STA, 32'h5);
      $display("test reset delay done");
      slp <= 1'b1;
      pin(1'b0);
      slp <= 1'b0;
      pin(1'b1);
      pin(1'b0);
      rd(A_CTL, 32'h0103_0028);
      chk(n_wake, 1);
      wr(A_CTL, 32'h0000_0028);
      idle(60);
      chk(n_rst, 3);
      wr(A_UNL, 32'h0);
      bus(1'b0, A_UNL, 32'h0);
      chk(rdat[0], 1'b0);
      wr(A_CTL, 32'h0080_0000);
      rd(A_CTL, 32'h0000_0028);
      chk(n_nmi, 6);
      chk(n_sw, 1);
      $display("test pins and relock done");
      test_done();
   end
endmodule // nrd_top_tb
